// ===== common/msc_pkg.sv
// constants, field layout and types of the modem serial control registers
package msc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 4;
  localparam int NUM_REGS = 7;
  localparam int MS_W = 9;

  // register numbers carried as the serial address
  localparam logic [2:0] ADDR_MODEM_CONFIG     = 3'h0;
  localparam logic [2:0] ADDR_CD_TIMING        = 3'h1;
  localparam logic [2:0] ADDR_FUNCTION_SELECT  = 3'h2;
  localparam logic [2:0] ADDR_RECV_LEVEL       = 3'h3;
  localparam logic [2:0] ADDR_TRANSMIT_GAIN    = 3'h4;
  localparam logic [2:0] ADDR_TONE_SELECT      = 3'h5;
  localparam logic [2:0] ADDR_RECEIVED_TONE    = 3'h6;

  // reset values
  localparam logic [3:0] RST_MODEM_CONFIG    = 4'h0;
  localparam logic [3:0] RST_CD_TIMING       = 4'h0;
  localparam logic [3:0] RST_FUNCTION_SELECT = 4'h0;
  localparam logic [3:0] RST_RECV_LEVEL      = 4'h0;
  localparam logic [3:0] RST_TRANSMIT_GAIN   = 4'h0;
  localparam logic [3:0] RST_TONE_SELECT     = 4'h0;
  localparam logic [3:0] RST_RECEIVED_TONE   = 4'h0;

  // field positions
  localparam int MC_STD_BIT   = 3;
  localparam int MC_CHAN_BIT  = 2;
  localparam int MC_TXDIS_BIT = 1;
  localparam logic [3:0] MC_WMASK = 4'he;
  localparam int CDT_FSK_LSB  = 2;
  localparam int CDT_TONE_LSB = 0;
  localparam int RL_AGC_LSB   = 2;
  localparam int RL_LEVEL_BIT = 1;
  localparam int RL_TEST_BIT  = 0;

  // carrier detect delays in ms, per timing code
  localparam logic [8:0] FSK_ON_MS_00  = 9'h1c2;
  localparam logic [8:0] FSK_ON_MS_01  = 9'h00f;
  localparam logic [8:0] FSK_ON_MS_10  = 9'h00f;
  localparam logic [8:0] FSK_ON_MS_11  = 9'h04b;
  localparam logic [8:0] FSK_OFF_MS_00 = 9'h01e;
  localparam logic [8:0] FSK_OFF_MS_01 = 9'h01e;
  localparam logic [8:0] FSK_OFF_MS_10 = 9'h00f;
  localparam logic [8:0] FSK_OFF_MS_11 = 9'h00a;
  localparam logic [8:0] TONE_ON_MS_00  = 9'h01e;
  localparam logic [8:0] TONE_ON_MS_01  = 9'h023;
  localparam logic [8:0] TONE_ON_MS_10  = 9'h02d;
  localparam logic [8:0] TONE_OFF_MS_00 = 9'h019;
  localparam logic [8:0] TONE_OFF_MS_01 = 9'h023;
  localparam logic [8:0] TONE_OFF_MS_10 = 9'h019;

  // agc range upper bound in dB
  localparam logic [4:0] AGC_DB_00 = 5'h14;
  localparam logic [4:0] AGC_DB_01 = 5'h0f;
  localparam logic [4:0] AGC_DB_10 = 5'h0a;
  localparam logic [4:0] AGC_DB_11 = 5'h05;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int CYCLES_PER_MS = MS_PS / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    MSC_S_HDR  = 2'b00,
    MSC_S_WR   = 2'b01,
    MSC_S_RD   = 2'b10,
    MSC_S_DONE = 2'b11
  } msc_ser_e;
endpackage : msc_pkg

// ===== common/msc_xfer_if.sv
// transaction carrier between the serial engine and the register bank
`timescale 1ns/1ps
interface msc_xfer_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [2:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  modport port (output wr_stb, rd_stb, addr, wdata, input rdata);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface : msc_xfer_if

// ===== hdl/msc_serial_port.sv
// serial control port engine, driven by sampled serial clock edges
`timescale 1ns/1ps
module msc_serial_port (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   sel_n,
  input  wire logic   sclk,
  input  wire logic   sdi,
  msc_xfer_if.port    x,
  output logic        sdo_r,
  output logic        sdo_oe_r
);
  msc_pkg::msc_ser_e state_r;
  logic       sclk_d_r;
  logic [1:0] cnt_r;
  logic [2:0] hdr_r;
  logic [3:0] sh_r;
  logic       rise;
  logic       fall;

  // transfers advance only on serial clock edges
  assign rise = sclk & ~sclk_d_r;
  assign fall = ~sclk & sclk_d_r;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= msc_pkg::MSC_S_HDR;
      cnt_r    <= 2'h0;
      hdr_r    <= 3'h0;
      sh_r     <= 4'h0;
      sdo_r    <= 1'b0;
      sdo_oe_r <= 1'b0;
      x.wr_stb <= 1'b0;
      x.rd_stb <= 1'b0;
      x.addr   <= 3'h0;
      x.wdata  <= 4'h0;
    end
    else
    begin
      x.wr_stb <= 1'b0;
      x.rd_stb <= 1'b0;
      if (sel_n)
      begin
        // deselect aborts whatever was in flight
        state_r  <= msc_pkg::MSC_S_HDR;
        cnt_r    <= 2'h0;
        sdo_oe_r <= 1'b0;
      end
      else
        case (state_r)
          msc_pkg::MSC_S_HDR:
            if (rise)
            begin
              hdr_r <= {hdr_r[1:0], sdi};
              cnt_r <= cnt_r + 2'h1;
              if (cnt_r == 2'h3)
              begin
                x.addr   <= {hdr_r[1:0], sdi};
                x.rd_stb <= hdr_r[2];
                state_r  <= hdr_r[2] ? msc_pkg::MSC_S_RD
                                     : msc_pkg::MSC_S_WR;
              end
            end
          msc_pkg::MSC_S_WR:
            if (rise)
            begin
              sh_r  <= {sh_r[2:0], sdi};
              cnt_r <= cnt_r + 2'h1;
              if (cnt_r == 2'h3)
              begin
                x.wdata  <= {sh_r[2:0], sdi};
                x.wr_stb <= 1'b1;
                state_r  <= msc_pkg::MSC_S_DONE;
              end
            end
          msc_pkg::MSC_S_RD:
            if (fall)
            begin
              // register read fresh at the first falling edge
              if (cnt_r == 2'h0)
              begin
                sdo_r    <= x.rdata[3];
                sh_r     <= {x.rdata[2:0], 1'b0};
                sdo_oe_r <= 1'b1;
              end
              else
              begin
                sdo_r <= sh_r[3];
                sh_r  <= {sh_r[2:0], 1'b0};
              end
              cnt_r <= cnt_r + 2'h1;
              if (cnt_r == 2'h3)
                state_r <= msc_pkg::MSC_S_DONE;
            end
          default: ; // done: lsb holds until deselect
        endcase
    end
  end

  read_msb_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sdo_oe_r) |-> sdo_r == $past(x.rdata[3]))
    else $error("first read bit is not the msb");
endmodule : msc_serial_port

// ===== hdl/msc_cd_timer.sv
// carrier detect qualifier: raw detect must persist for a delay in ms
`timescale 1ns/1ps
module msc_cd_timer #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ms_tick,
  input  wire logic         raw,
  input  wire logic [W-1:0] on_ms,
  input  wire logic [W-1:0] off_ms,
  output logic              det_r
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] dly;

  assign cnt_nxt = cnt_r + W'(1);
  assign dly = det_r ? off_ms : on_ms;

  // a glitch back to the old level restarts the wait
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      det_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (raw == det_r)
      cnt_r <= '0;
    else if (ms_tick)
    begin
      if (cnt_nxt >= dly)
      begin
        det_r <= raw;
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_nxt;
    end
  end
endmodule : msc_cd_timer

// ===== hdl/msc_top.sv
// Function
// - transactions run only while port select is held low
// - select going high aborts the transaction and floats serial output
// - seven 4-bit registers addressed by the serial register number
// - reset pin low or power loss restores all register defaults
// - modem config defaults to 1200 baud, receive channel, tx enabled
// - tone carrier detect defaults: on 30 ms, off 25 ms
// - fsk carrier detect defaults: on 450 ms, off 30 ms
// - function select defaults to fsk modem mode
// - receive config defaults to widest agc range, high detect level
// - transmit gain defaults to maximum, no attenuation
// - tone select defaults to the 941 plus 1633 Hz pair
// - fsk on delay from bits 3:2: 450, 15, 15, 75 ms
// - fsk off delay from bits 3:2: 30, 30, 15, 10 ms
// - tone on delay from bits 1:0: 30, 35, 45 ms
// - tone off delay from bits 1:0: 25, 35, 25 ms
// - receive bits 3:2 give agc upper bound 20, 15, 10, 5 dB
// - received tone register holds the last decoded digit
// - frame: direction bit, 3-bit address msb first, four data bits
// - read data leaves on falling edges msb first, lsb then held until deselect floats it
// - writes to read-only registers or bits change nothing
// - port logic advances only on the host serial clock
`timescale 1ns/1ps
module msc_top #(
  parameter int CYCLES_PER_MS = msc_pkg::CYCLES_PER_MS
) (
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       RESET_PIN_N,
  input  wire logic       PORT_SELECT_N,
  input  wire logic       PORT_SERIAL_CLOCK,
  input  wire logic       PORT_SERIAL_IN,
  output logic            PORT_SERIAL_OUT,
  output logic            PORT_SERIAL_OUT_EN,
  input  wire logic [3:0] TONE_CODE,
  input  wire logic       TONE_STROBE,
  input  wire logic       FSK_CARRIER_RAW,
  input  wire logic       TONE_CARRIER_RAW,
  output logic [3:0]      MODEM_CONFIG,
  output logic [3:0]      CARRIER_DETECT_TIMING,
  output logic [3:0]      FUNCTION_SELECT,
  output logic [3:0]      RECEIVE_LEVEL_CONFIG,
  output logic [3:0]      TRANSMIT_GAIN,
  output logic [3:0]      TONE_SELECT,
  output logic [4:0]      AGC_UPPER_DB,
  output logic            FSK_CARRIER_DETECT,
  output logic            TONE_CARRIER_DETECT
);
  localparam int NS = 6;
  localparam logic [NS-1:0] SYNC_RST = 6'h30;
  localparam int MSW = $clog2(CYCLES_PER_MS + 1);

  logic [NS-1:0] async_in;
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  logic          pin_rst_n_s;
  logic          sel_n_s;
  logic [3:0]    reg_r [msc_pkg::NUM_REGS];
  logic [MSW-1:0] ms_cnt_r;
  logic          ms_tick_r;
  logic [msc_pkg::MS_W-1:0] on_ms  [2];
  logic [msc_pkg::MS_W-1:0] off_ms [2];
  logic [1:0]    cd_raw;
  logic [1:0]    cd_det;

  msc_xfer_if xf ();

  function automatic logic [3:0] reg_default(input logic [2:0] a);
    case (a)
      msc_pkg::ADDR_MODEM_CONFIG:    reg_default = msc_pkg::RST_MODEM_CONFIG;
      msc_pkg::ADDR_CD_TIMING:       reg_default = msc_pkg::RST_CD_TIMING;
      msc_pkg::ADDR_FUNCTION_SELECT:
        reg_default = msc_pkg::RST_FUNCTION_SELECT;
      msc_pkg::ADDR_RECV_LEVEL:      reg_default = msc_pkg::RST_RECV_LEVEL;
      msc_pkg::ADDR_TRANSMIT_GAIN:
        reg_default = msc_pkg::RST_TRANSMIT_GAIN;
      msc_pkg::ADDR_TONE_SELECT:     reg_default = msc_pkg::RST_TONE_SELECT;
      default:                       reg_default = msc_pkg::RST_RECEIVED_TONE;
    endcase
  endfunction : reg_default

  // writable bits per register; the received tone takes none
  function automatic logic [3:0] reg_wmask(input logic [2:0] a);
    case (a)
      msc_pkg::ADDR_MODEM_CONFIG:  reg_wmask = msc_pkg::MC_WMASK;
      msc_pkg::ADDR_RECEIVED_TONE: reg_wmask = 4'h0;
      3'h7:                        reg_wmask = 4'h0;
      default:                     reg_wmask = 4'hf;
    endcase
  endfunction : reg_wmask

  function automatic logic [8:0] fsk_delay(input logic [1:0] c,
                                           input logic off);
    case (c)
      2'h0:    fsk_delay = off ? msc_pkg::FSK_OFF_MS_00
                               : msc_pkg::FSK_ON_MS_00;
      2'h1:    fsk_delay = off ? msc_pkg::FSK_OFF_MS_01
                               : msc_pkg::FSK_ON_MS_01;
      2'h2:    fsk_delay = off ? msc_pkg::FSK_OFF_MS_10
                               : msc_pkg::FSK_ON_MS_10;
      default: fsk_delay = off ? msc_pkg::FSK_OFF_MS_11
                               : msc_pkg::FSK_ON_MS_11;
    endcase
  endfunction : fsk_delay

  // code 11 has no defined timing; it behaves as code 10
  function automatic logic [8:0] tone_delay(input logic [1:0] c,
                                            input logic off);
    case (c)
      2'h0:    tone_delay = off ? msc_pkg::TONE_OFF_MS_00
                                : msc_pkg::TONE_ON_MS_00;
      2'h1:    tone_delay = off ? msc_pkg::TONE_OFF_MS_01
                                : msc_pkg::TONE_ON_MS_01;
      default: tone_delay = off ? msc_pkg::TONE_OFF_MS_10
                                : msc_pkg::TONE_ON_MS_10;
    endcase
  endfunction : tone_delay

  function automatic logic [4:0] agc_db(input logic [1:0] c);
    case (c)
      2'h0:    agc_db = msc_pkg::AGC_DB_00;
      2'h1:    agc_db = msc_pkg::AGC_DB_01;
      2'h2:    agc_db = msc_pkg::AGC_DB_10;
      default: agc_db = msc_pkg::AGC_DB_11;
    endcase
  endfunction : agc_db

  // every pin from outside this clock passes two flops
  assign async_in = {RESET_PIN_N, PORT_SELECT_N, PORT_SERIAL_CLOCK,
                     PORT_SERIAL_IN, FSK_CARRIER_RAW, TONE_CARRIER_RAW};

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign pin_rst_n_s = sync_r[5];
  assign sel_n_s     = sync_r[4];
  assign cd_raw      = sync_r[1:0];

  msc_serial_port u_port (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .sel_n    (sel_n_s),
    .sclk     (sync_r[3]),
    .sdi      (sync_r[2]),
    .x        (xf.port),
    .sdo_r    (PORT_SERIAL_OUT),
    .sdo_oe_r (PORT_SERIAL_OUT_EN)
  );

  // unmapped address reads back zero
  assign xf.rdata = (xf.addr < 3'(msc_pkg::NUM_REGS)) ? reg_r[xf.addr]
                                                      : 4'h0;

  // register bank; the reset pin acts while held low
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < msc_pkg::NUM_REGS; i++)
        reg_r[i] <= reg_default(3'(i));
    end
    else if (!pin_rst_n_s)
    begin
      for (int i = 0; i < msc_pkg::NUM_REGS; i++)
        reg_r[i] <= reg_default(3'(i));
    end
    else
    begin
      if (xf.wr_stb && reg_wmask(xf.addr) != 4'h0)
        reg_r[xf.addr] <= (xf.wdata & reg_wmask(xf.addr))
                        | (reg_r[xf.addr] & ~reg_wmask(xf.addr));
      if (TONE_STROBE)
        reg_r[msc_pkg::ADDR_RECEIVED_TONE] <= TONE_CODE;
    end
  end

  assign MODEM_CONFIG          = reg_r[msc_pkg::ADDR_MODEM_CONFIG];
  assign CARRIER_DETECT_TIMING = reg_r[msc_pkg::ADDR_CD_TIMING];
  assign FUNCTION_SELECT       = reg_r[msc_pkg::ADDR_FUNCTION_SELECT];
  assign RECEIVE_LEVEL_CONFIG  = reg_r[msc_pkg::ADDR_RECV_LEVEL];
  assign TRANSMIT_GAIN         = reg_r[msc_pkg::ADDR_TRANSMIT_GAIN];
  assign TONE_SELECT           = reg_r[msc_pkg::ADDR_TONE_SELECT];

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
    if (SYS_RST)
      AGC_UPPER_DB <= msc_pkg::AGC_DB_00;
    else
      AGC_UPPER_DB <= agc_db(RECEIVE_LEVEL_CONFIG[
                        msc_pkg::RL_AGC_LSB +: 2]);

  // millisecond tick keeps the carrier counters narrow
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ms_cnt_r  <= '0;
      ms_tick_r <= 1'b0;
    end
    else if (ms_cnt_r == MSW'(CYCLES_PER_MS - 1))
    begin
      ms_cnt_r  <= '0;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      ms_cnt_r  <= ms_cnt_r + MSW'(1);
      ms_tick_r <= 1'b0;
    end
  end

  // channel 1 is fsk, channel 0 the tone receiver
  assign on_ms[1]  = fsk_delay(CARRIER_DETECT_TIMING[
                       msc_pkg::CDT_FSK_LSB +: 2], 1'b0);
  assign off_ms[1] = fsk_delay(CARRIER_DETECT_TIMING[
                       msc_pkg::CDT_FSK_LSB +: 2], 1'b1);
  assign on_ms[0]  = tone_delay(CARRIER_DETECT_TIMING[
                       msc_pkg::CDT_TONE_LSB +: 2], 1'b0);
  assign off_ms[0] = tone_delay(CARRIER_DETECT_TIMING[
                       msc_pkg::CDT_TONE_LSB +: 2], 1'b1);

  for (genvar g = 0; g < 2; g++)
  begin : g_cd
    msc_cd_timer #(.W(msc_pkg::MS_W)) u_cd (
      .clk     (CORE_CLK),
      .rst     (SYS_RST),
      .ms_tick (ms_tick_r),
      .raw     (cd_raw[g]),
      .on_ms   (on_ms[g]),
      .off_ms  (off_ms[g]),
      .det_r   (cd_det[g])
    );
  end

  assign FSK_CARRIER_DETECT  = cd_det[1];
  assign TONE_CARRIER_DETECT = cd_det[0];

  abort_hiz_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    sel_n_s |=> !PORT_SERIAL_OUT_EN)
    else $error("serial output driven after deselect");

  sel_gate_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PORT_SERIAL_OUT_EN |-> !$past(sel_n_s))
    else $error("serial output driven without select");

  write_sel_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    xf.wr_stb |-> $past(!sel_n_s, 1) && !xf.rd_stb)
    else $error("write strobe outside a selected frame");

  write_store_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    xf.wr_stb && xf.addr == msc_pkg::ADDR_TRANSMIT_GAIN && pin_rst_n_s
    |=> TRANSMIT_GAIN == $past(xf.wdata))
    else $error("write did not reach transmit gain");

  ro_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    xf.wr_stb && xf.addr == msc_pkg::ADDR_RECEIVED_TONE && !TONE_STROBE
    && pin_rst_n_s
    |=> $stable(reg_r[msc_pkg::ADDR_RECEIVED_TONE]))
    else $error("read-only register changed by a write");

  spare_bit_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    MODEM_CONFIG[0] == 1'b0)
    else $error("non-working config bit became set");

  pin_reset_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !pin_rst_n_s |=> MODEM_CONFIG == msc_pkg::RST_MODEM_CONFIG
      && CARRIER_DETECT_TIMING == msc_pkg::RST_CD_TIMING
      && TONE_SELECT == msc_pkg::RST_TONE_SELECT ##2
      AGC_UPPER_DB == msc_pkg::AGC_DB_00)
    else $error("reset pin did not restore defaults");

  tone_latch_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    TONE_STROBE && pin_rst_n_s
    |=> reg_r[msc_pkg::ADDR_RECEIVED_TONE] == $past(TONE_CODE))
    else $error("decoded digit not captured");

  cd_tick_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $changed(FSK_CARRIER_DETECT) |-> $past(ms_tick_r)
      && FSK_CARRIER_DETECT == $past(cd_raw[1]))
    else $error("carrier detect moved off the ms tick");

  // agc bound follows the receive range code one cycle later
  agc_widest_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    RECEIVE_LEVEL_CONFIG[msc_pkg::RL_AGC_LSB +: 2] == 2'h0
    |=> AGC_UPPER_DB == msc_pkg::AGC_DB_00)
    else $error("widest agc code gave a wrong bound");

  agc_narrow_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    RECEIVE_LEVEL_CONFIG[msc_pkg::RL_AGC_LSB +: 2] == 2'h3
    |=> AGC_UPPER_DB == msc_pkg::AGC_DB_11)
    else $error("narrowest agc code gave a wrong bound");

  unmapped_rd_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    xf.addr == 3'h7 |-> xf.rdata == 4'h0)
    else $error("unmapped register read back nonzero");

  write_pulse_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    xf.wr_stb |=> !xf.wr_stb)
    else $error("write strobe held longer than one cycle");

  hdr_float_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    xf.rd_stb |-> !PORT_SERIAL_OUT_EN)
    else $error("serial output driven during the header");

  abort_write_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    sel_n_s |=> !xf.wr_stb)
    else $error("write strobe after deselect");

  pin_rest_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    !pin_rst_n_s |=> FUNCTION_SELECT == msc_pkg::RST_FUNCTION_SELECT
      && RECEIVE_LEVEL_CONFIG == msc_pkg::RST_RECV_LEVEL
      && TRANSMIT_GAIN == msc_pkg::RST_TRANSMIT_GAIN)
    else $error("reset pin left a register off its default");

  tone_keep_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    !TONE_STROBE && pin_rst_n_s
    |=> $stable(reg_r[msc_pkg::ADDR_RECEIVED_TONE]))
    else $error("decoded digit changed without a strobe");

  // a stuck tick would make every carrier delay count core cycles instead of milliseconds
  ms_tick_a: assert property (@(posedge CORE_CLK)
    disable iff (SYS_RST)
    ms_tick_r |=> !ms_tick_r)
    else $error("millisecond tick lasted more than one cycle");

  pin_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !pin_rst_n_s);
  read_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
    xf.rd_stb ##[1:200] PORT_SERIAL_OUT_EN);
  write_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
    xf.wr_stb && xf.addr == msc_pkg::ADDR_FUNCTION_SELECT);
  abort_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PORT_SERIAL_OUT_EN ##1 sel_n_s);
  cd_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(TONE_CARRIER_DETECT));
endmodule : msc_top

// ===== verif/msc_host_model.sv
// host side model that runs frames on the serial control port
`timescale 1ns/1ps
module msc_host_model (
  output logic      sel_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_en
);
  localparam time HALF = 40ns;

  initial
  begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end

  // serial clock stands low between frames; nrise below 8 cuts a frame
  task automatic frame(input logic rd, input logic [2:0] a,
                       input logic [3:0] d, input int nrise,
                       output logic [3:0] q, output logic en_ok);
    logic [7:0] bits;
    bits  = {rd, a, d};
    q     = 4'h0;
    en_ok = 1'b1;
    sel_n = 1'b0;
    for (int k = 0; k < nrise; k++)
    begin
      sdi = bits[7-k];
      #HALF;
      sclk = 1'b1;
      if (sdo_en !== (rd && k >= 4))
        en_ok = 1'b0;
      if (rd && k >= 4)
        q[7-k] = sdo;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    sel_n = 1'b1;
    // released data line shows the inverse so a stale value cannot pass
    sdi = ~sdi;
    #HALF;
  endtask : frame
endmodule : msc_host_model

// ===== verif/test_modem_serial_control_registers.sv
// self-checking bench of the modem serial control registers
`timescale 1ns/1ps
module test_modem_serial_control_registers;
  localparam int PER_MS = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       rpin_n = 1'b1;
  logic [3:0] tcode = 4'h0;
  logic       tstb = 1'b0;
  logic       fsk_raw = 1'b0;
  logic       tone_raw = 1'b0;
  logic       sel_n, sclk, sdi, sdo, sdo_en;
  logic [3:0] mc, cdt, fs, rl, tg, ts, q;
  logic [4:0] agc;
  logic       fsk_det, tone_det, ok;
  int         errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  // rows: address, written value, value read back
  logic [10:0] rows [9] = '{{3'h0, 4'hf, 4'he}, {3'h0, 4'h1, 4'h0},
    {3'h1, 4'ha, 4'ha}, {3'h2, 4'h9, 4'h9}, {3'h3, 4'h5, 4'h5},
    {3'h4, 4'hf, 4'hf}, {3'h5, 4'hc, 4'hc}, {3'h6, 4'h7, 4'h0},
    {3'h7, 4'h3, 4'h0}};
  // timing code, fsk on, fsk off, tone on, tone off in ms
  int cds [3][5] = '{'{0, 450, 30, 30, 25}, '{6, 15, 30, 45, 25},
    '{15, 75, 10, 45, 25}};

  always #2.5 clk = ~clk;

  msc_top #(.CYCLES_PER_MS(PER_MS)) dut_u (
    .CORE_CLK(clk), .SYS_RST(rst), .RESET_PIN_N(rpin_n),
    .PORT_SELECT_N(sel_n), .PORT_SERIAL_CLOCK(sclk),
    .PORT_SERIAL_IN(sdi), .PORT_SERIAL_OUT(sdo),
    .PORT_SERIAL_OUT_EN(sdo_en), .TONE_CODE(tcode), .TONE_STROBE(tstb),
    .FSK_CARRIER_RAW(fsk_raw), .TONE_CARRIER_RAW(tone_raw),
    .MODEM_CONFIG(mc), .CARRIER_DETECT_TIMING(cdt),
    .FUNCTION_SELECT(fs), .RECEIVE_LEVEL_CONFIG(rl),
    .TRANSMIT_GAIN(tg), .TONE_SELECT(ts), .AGC_UPPER_DB(agc),
    .FSK_CARRIER_DETECT(fsk_det), .TONE_CARRIER_DETECT(tone_det)
  );

  msc_host_model host_u (
    .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_en(sdo_en)
  );

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [4:0] exp,
                       input logic [4:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [3:0] par(input logic [2:0] a);
    case (a)
      3'h0: par = mc;
      3'h1: par = cdt;
      3'h2: par = fs;
      3'h3: par = rl;
      3'h4: par = tg;
      3'h5: par = ts;
      default: par = 4'h0;
    endcase
  endfunction : par

  // a frame cut short leaves select high before its eighth rise
  task automatic xfer(input logic rd, input logic [2:0] a,
                      input logic [3:0] d, input int nrise);
    @(posedge clk);
    #1;
    host_u.frame(rd, a, d, nrise, q, ok);
    check("drive enable", 5'h1, {4'h0, ok});
    repeat (4) @(posedge clk);
  endtask : xfer

  task automatic rd_chk(input logic [2:0] a, input logic [3:0] exp);
    xfer(1'b1, a, 4'h0, 8);
    check("read data", {1'b0, exp}, {1'b0, q});
    check("released", 5'h0, {4'h0, sdo_en});
  endtask : rd_chk

  // detect must hold off until the delay has run, then follow raw
  task automatic cd_one(input logic fsk, input int on, input int off);
    for (int s = 0; s < 2; s++)
    begin
      #1;
      if (fsk)
        fsk_raw = (s == 0);
      else
        tone_raw = (s == 0);
      repeat (((s == 0 ? on : off) - 2) * PER_MS) @(posedge clk);
      check("early detect", {4'h0, s[0]},
            {4'h0, fsk ? fsk_det : tone_det});
      repeat (3 * PER_MS + 6) @(posedge clk);
      check("detect", {4'h0, ~s[0]},
            {4'h0, fsk ? fsk_det : tone_det});
    end
  endtask : cd_one

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      $display("Error timeout expected end seen hang");
      report_and_stop;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 7; a++)
    begin
      rd_chk(a[2:0], 4'h0);
      check("pin default", 5'h0, {1'b0, par(a[2:0])});
    end
    check("agc default", 5'h14, agc);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b0, 3'h1, cds[i][0][3:0], 8);
      cd_one(1'b1, cds[i][1], cds[i][2]);
      cd_one(1'b0, cds[i][3], cds[i][4]);
    end
    foreach (rows[i])
    begin
      xfer(1'b0, rows[i][10:8], rows[i][7:4], 8);
      rd_chk(rows[i][10:8], rows[i][3:0]);
      if (rows[i][10:8] < 3'h6)
        check("pin value", {1'b0, rows[i][3:0]},
              {1'b0, par(rows[i][10:8])});
    end
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b0, 3'h3, {c[1:0], 2'b00}, 8);
      repeat (2) @(posedge clk);
      check("agc bound", 5'(20 - 5 * c), agc);
    end
    @(posedge clk);
    #1;
    tcode = 4'h9;
    tstb = 1'b1;
    @(posedge clk);
    #1;
    tstb = 1'b0;
    rd_chk(3'h6, 4'h9);
    xfer(1'b0, 3'h6, 4'h3, 8);
    rd_chk(3'h6, 4'h9);
    xfer(1'b0, 3'h4, 4'h3, 6);
    check("aborted write", 5'h0f, {1'b0, tg});
    @(posedge clk);
    #1;
    host_u.frame(1'b1, 3'h2, 4'h0, 6, q, ok);
    check("abort float", 5'h0, {4'h0, sdo_en});
    @(posedge clk);
    #1;
    rpin_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rpin_n = 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 6; a++)
      check("pin reset", 5'h0, {1'b0, par(a[2:0])});
    check("agc reset", 5'h14, agc);
    rd_chk(3'h4, 4'h0);
    report_and_stop;
  end
endmodule : test_modem_serial_control_registers
